// ==== drive_terminal_regs.svh ====
// register offsets, fields, reset values and timing counts of the terminal logic
`ifndef DRIVE_TERMINAL_REGS_SVH
`define DRIVE_TERMINAL_REGS_SVH
`define OFS_CTRL 12'h000
`define OFS_SETPOINT 12'h004
`define OFS_LIMITS 12'h008
`define OFS_MATCH 12'h00C
`define OFS_BAND 12'h010
`define OFS_COUNT_CFG 12'h014
`define OFS_OUT_SEL 12'h018
`define OFS_DRIVE 12'h01C
`define OFS_STATUS 12'h020
`define OFS_COUNT 12'h024
`define OFS_RUN_FREQ 12'h028
`define OFS_CMD 12'h02C
`define MAX_FREQ_RST 16'h9C40
`define MIN_FREQ_RST 16'h0000
`define BAND_RST 16'h0032
`define OUT_SEL_RST 32'h00020501
`define STEP_FINE 16'h0001
`define STEP_COARSE 16'h000A
`define CMD_CONFIRM 0
`define CMD_COUNT_CLR 1
`define DEBOUNCE_MS 2
`define DEBOUNCE_CYC (`DEBOUNCE_MS * 200000)
`define FAST_REPEAT_NS 5000000
`define FAST_REPEAT_CYC (`FAST_REPEAT_NS / 5)
`define SLOW_REPEAT_NS 50000000
`define SLOW_REPEAT_CYC (`SLOW_REPEAT_NS / 5)
`define FAST_STEPS 20
`define COUNT_MAX 16'hFFFF
`endif

// ==== drive_terminal_pkg.sv ====
// types of the terminal function logic
package drive_terminal_pkg;
  typedef enum logic [1:0] {
    HOLD_IDLE = 2'b00,
    HOLD_FAST = 2'b01,
    HOLD_SLOW = 2'b10
  } hold_state_t;
  typedef logic [5:0] out_code_t;
endpackage

// ==== drive_terminal_function_logic.sv ====
// terminal function logic: up/down adjust, pulse counter, contacts, monitor pulse
// Operation
// - up alone raises running setpoint
// - down alone lowers running setpoint
// - up and down together change nothing
// - adjust only when source select is zero
// - raising saturates at maximum frequency
// - lowering stops at lower limit
// - only stored setpoint survives power loss; reset here clears it to 0 like all other state except max frequency, match band and out_sel
// - panel value applies on confirm, stored
// - held key repeats fast then steady
// - target reach stops counting, drives code 16
// - counting resumes only after reset
// - counter saturates at 65535
// - four selectors, code zero inactive
// - code 1 running, code 2 fault
// - code 3 below start, 5 at setpoint
// - codes 6, 7 match frequencies
// - code 8 accel, code 9 decel
// - codes 14, 15 one-cycle step pulses
// - code 16 count equal, 17 at-or-above
// - code 27 drawing done, clears on stop
// - monitor codes 4-7 give pulse trains
// - each activation steps 1 unit, or 10 with coarse step
// - step select picks 0.01 or 0.1 Hz
// - match band acts as hysteresis
`timescale 1ns/1ps
`include "drive_terminal_regs.svh"
module drive_terminal_function_logic #(
  parameter int DEBOUNCE_CYCLES = `DEBOUNCE_CYC,
  parameter int FAST_CYCLES = `FAST_REPEAT_CYC,
  parameter int SLOW_CYCLES = `SLOW_REPEAT_CYC,
  parameter int FAST_STEPS = `FAST_STEPS,
  parameter int PULSE_DIV = 2000
)(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic up_in,
  input wire logic down_in,
  input wire logic count_in,
  input wire logic count_reset_in,
  input wire logic [15:0] output_frequency,
  input wire logic drive_running,
  input wire logic run_command,
  input wire logic fault_detected,
  input wire logic accelerating,
  input wire logic decelerating,
  input wire logic step_done,
  input wire logic cycle_done,
  input wire logic drawing_done,
  output logic [3:0] contact_out,
  output logic monitor_output,
  output logic [15:0] running_setpoint
);
  import drive_terminal_pkg::*;

  initial
  begin
    if (DEBOUNCE_CYCLES < 1 || FAST_CYCLES < 1 || SLOW_CYCLES < 1 || FAST_STEPS < 1
        || PULSE_DIV < 2)
    begin
      $error("drive_terminal_function_logic: bad parameter");
    end
  end

  typedef struct packed {
    logic [1:0] freq_source_select;
    logic adjust_step_select;
    logic adjust_retain_select;
    logic [2:0] monitor_output_select;
    logic [15:0] stored_frequency_setpoint;
    logic [15:0] max_freq;
    logic [15:0] min_freq;
    logic [15:0] start_freq;
    logic [15:0] match_frequency_first;
    logic [15:0] match_frequency_second;
    logic [15:0] match_frequency_band;
    logic [15:0] count_target_value;
    logic [15:0] count_intermediate_value;
    logic [31:0] out_sel;
    logic [15:0] setpoint;
    logic [15:0] count;
    logic reached;
    logic [31:0] deb_cnt;
    logic cnt_level;
    logic match1;
    logic match2;
    logic drawn;
    hold_state_t hold;
    logic [31:0] hold_cnt;
    logic [15:0] fast_cnt;
    logic [31:0] pulse_acc;
    logic [15:0] pulse_tick;
    logic pulse_level;
    logic [3:0] contacts;
    logic [31:0] rdata;
    logic ready;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  logic [31:0] st_word;
  logic [15:0] step;
  logic [15:0] lower;
  logic [16:0] sum;
  logic adj_ok;
  logic fire;
  logic rise;
  logic wr;
  logic rd;
  logic [3:0] cond [0:31];
  logic [31:0] mult;

  always_comb
  begin
    s_nxt = s_r;
    wr = psel && penable && pwrite && s_r.ready;
    rd = psel && penable && !pwrite && !s_r.ready;
    step = s_r.adjust_step_select ? `STEP_COARSE : `STEP_FINE;
    lower = s_r.min_freq;
    adj_ok = (s_r.freq_source_select == 2'b00);
    fire = 1'b0;
    sum = 17'h00000;
    rise = 1'b0;
    mult = 32'h00000000;
    st_word = {20'h00000, s_r.contacts, 1'b0, s_r.monitor_output_select[0],
               s_r.match2, s_r.match1, s_r.drawn, s_r.reached, s_r.hold};

    // apb slave, one wait state
    s_nxt.ready = psel && penable && !s_r.ready;
    if (wr)
    begin
      case (paddr)
        `OFS_CTRL:
        begin
          s_nxt.freq_source_select = pwdata[1:0];
          s_nxt.adjust_step_select = pwdata[2];
          s_nxt.adjust_retain_select = pwdata[3];
          s_nxt.monitor_output_select = pwdata[6:4];
        end
        `OFS_SETPOINT: s_nxt.stored_frequency_setpoint = pwdata[15:0];
        `OFS_LIMITS:
        begin
          s_nxt.max_freq = pwdata[15:0];
          s_nxt.min_freq = pwdata[31:16];
        end
        `OFS_MATCH:
        begin
          s_nxt.match_frequency_first = pwdata[15:0];
          s_nxt.match_frequency_second = pwdata[31:16];
        end
        `OFS_BAND:
        begin
          s_nxt.match_frequency_band = pwdata[15:0];
          s_nxt.start_freq = pwdata[31:16];
        end
        `OFS_COUNT_CFG:
        begin
          s_nxt.count_target_value = pwdata[15:0];
          s_nxt.count_intermediate_value = pwdata[31:16];
        end
        `OFS_OUT_SEL: s_nxt.out_sel = pwdata;
        `OFS_CMD:
        begin
          if (pwdata[`CMD_CONFIRM])
          begin
            // panel value applied and kept
            s_nxt.stored_frequency_setpoint = pwdata[31:16];
            s_nxt.setpoint = pwdata[31:16];
          end
        end
        default:
        begin
        end
      endcase
    end
    if (rd)
    begin
      case (paddr)
        `OFS_CTRL: s_nxt.rdata = {25'h0000000, s_r.monitor_output_select,
                                 s_r.adjust_retain_select, s_r.adjust_step_select,
                                 s_r.freq_source_select};
        `OFS_SETPOINT: s_nxt.rdata = {16'h0000, s_r.stored_frequency_setpoint};
        `OFS_LIMITS: s_nxt.rdata = {s_r.min_freq, s_r.max_freq};
        `OFS_MATCH: s_nxt.rdata = {s_r.match_frequency_second, s_r.match_frequency_first};
        `OFS_BAND: s_nxt.rdata = {s_r.start_freq, s_r.match_frequency_band};
        `OFS_COUNT_CFG: s_nxt.rdata = {s_r.count_intermediate_value, s_r.count_target_value};
        `OFS_OUT_SEL: s_nxt.rdata = s_r.out_sel;
        `OFS_DRIVE: s_nxt.rdata = {16'h0000, output_frequency};
        `OFS_STATUS: s_nxt.rdata = st_word;
        `OFS_COUNT: s_nxt.rdata = {16'h0000, s_r.count};
        `OFS_RUN_FREQ: s_nxt.rdata = {16'h0000, s_r.setpoint};
        default: s_nxt.rdata = 32'h00000000;
      endcase
    end

    // up/down hold-repeat
    if (adj_ok && (up_in ^ down_in))
    begin
      case (s_r.hold)
        HOLD_IDLE:
        begin
          fire = 1'b1;
          s_nxt.hold = HOLD_FAST;
          s_nxt.hold_cnt = 32'h00000000;
          s_nxt.fast_cnt = 16'h0000;
        end
        HOLD_FAST:
        begin
          if (s_r.hold_cnt >= 32'(FAST_CYCLES - 1))
          begin
            fire = 1'b1;
            s_nxt.hold_cnt = 32'h00000000;
            s_nxt.fast_cnt = s_r.fast_cnt + 16'h0001;
            if (s_r.fast_cnt >= 16'(FAST_STEPS - 1))
            begin
              s_nxt.hold = HOLD_SLOW;
            end
          end
          else
          begin
            s_nxt.hold_cnt = s_r.hold_cnt + 32'h00000001;
          end
        end
        HOLD_SLOW:
        begin
          if (s_r.hold_cnt >= 32'(SLOW_CYCLES - 1))
          begin
            fire = 1'b1;
            s_nxt.hold_cnt = 32'h00000000;
          end
          else
          begin
            s_nxt.hold_cnt = s_r.hold_cnt + 32'h00000001;
          end
        end
        default: s_nxt.hold = HOLD_IDLE;
      endcase
    end
    else
    begin
      s_nxt.hold = HOLD_IDLE;
    end
    if (fire && up_in)
    begin
      sum = {1'b0, s_r.setpoint} + {1'b0, step};
      s_nxt.setpoint = (sum > {1'b0, s_r.max_freq}) ? s_r.max_freq : sum[15:0];
    end
    if (fire && down_in)
    begin
      s_nxt.setpoint = (s_r.setpoint < lower + step) ? lower : s_r.setpoint - step;
    end
    // not-retained changes fall back to stored value on stop
    if (!drive_running && !run_command && !s_r.adjust_retain_select)
    begin
      s_nxt.setpoint = s_r.stored_frequency_setpoint;
    end

    // counter debounce and count
    if (count_in != s_r.cnt_level)
    begin
      if (s_r.deb_cnt >= 32'(DEBOUNCE_CYCLES - 1))
      begin
        s_nxt.cnt_level = count_in;
        s_nxt.deb_cnt = 32'h00000000;
        rise = count_in;
      end
      else
      begin
        s_nxt.deb_cnt = s_r.deb_cnt + 32'h00000001;
      end
    end
    else
    begin
      s_nxt.deb_cnt = 32'h00000000;
    end
    if (rise && !s_r.reached && s_r.count != `COUNT_MAX)
    begin
      s_nxt.count = s_r.count + 16'h0001;
      if (s_r.count + 16'h0001 == s_r.count_target_value)
      begin
        s_nxt.reached = 1'b1;
      end
    end
    if (count_reset_in || (wr && paddr == `OFS_CMD && pwdata[`CMD_COUNT_CLR]))
    begin
      s_nxt.count = 16'h0000;
      s_nxt.reached = 1'b0;
    end

    // match hysteresis
    if (output_frequency >= s_r.match_frequency_first + s_r.match_frequency_band)
    begin
      s_nxt.match1 = 1'b1;
    end
    else if (output_frequency + s_r.match_frequency_band < s_r.match_frequency_first)
    begin
      s_nxt.match1 = 1'b0;
    end
    if (output_frequency >= s_r.match_frequency_second + s_r.match_frequency_band)
    begin
      s_nxt.match2 = 1'b1;
    end
    else if (output_frequency + s_r.match_frequency_band < s_r.match_frequency_second)
    begin
      s_nxt.match2 = 1'b0;
    end

    // drawing latch, set wins
    if (drawing_done)
    begin
      s_nxt.drawn = 1'b1;
    end
    else if (!drive_running)
    begin
      s_nxt.drawn = 1'b0;
    end

    // contact functions
    for (int i = 0; i < 32; i++)
    begin
      cond[i] = 4'h0;
    end
    cond[1] = {4{drive_running || run_command}};
    cond[2] = {4{fault_detected}};
    cond[3] = {4{output_frequency < s_r.start_freq}};
    cond[5] = {4{output_frequency == s_r.setpoint}};
    cond[6] = {4{s_r.match1}};
    cond[7] = {4{s_r.match2}};
    cond[8] = {4{accelerating}};
    cond[9] = {4{decelerating}};
    cond[14] = {4{step_done}};
    cond[15] = {4{cycle_done}};
    cond[16] = {4{s_r.count == s_r.count_target_value}};
    cond[17] = {4{s_r.count >= s_r.count_intermediate_value}};
    cond[27] = {4{s_r.drawn}};
    for (int k = 0; k < 4; k++)
    begin
      // codes above 31 and code 0 stay off
      s_nxt.contacts[k] = (s_r.out_sel[k*8 +: 6] < 6'h20) ?
                          cond[s_r.out_sel[k*8 +: 5]][k] : 1'b0;
    end

    // monitor pulse train: accumulate 2*freq*mult per tick
    case (s_r.monitor_output_select)
      3'h4: mult = 32'h00000001;
      3'h5: mult = 32'h00000002;
      3'h6: mult = 32'h00000003;
      3'h7: mult = 32'h00000006;
      default: mult = 32'h00000000;
    endcase
    if (mult == 32'h00000000)
    begin
      s_nxt.pulse_level = 1'b0;
      s_nxt.pulse_acc = 32'h00000000;
    end
    else if (s_r.pulse_tick >= 16'(PULSE_DIV - 1))
    begin
      s_nxt.pulse_tick = 16'h0000;
      // half-period toggles: 100 units per hz, 2 toggles per pulse
      s_nxt.pulse_acc = s_r.pulse_acc + {16'h0000, output_frequency} * mult * 32'h2;
      if (s_nxt.pulse_acc >= 32'(200000000 / PULSE_DIV) * 32'd100)
      begin
        s_nxt.pulse_acc = s_nxt.pulse_acc - 32'(200000000 / PULSE_DIV) * 32'd100;
        s_nxt.pulse_level = !s_r.pulse_level;
      end
    end
    else
    begin
      s_nxt.pulse_tick = s_r.pulse_tick + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      s_r <= '0;
      s_r.max_freq <= `MAX_FREQ_RST;
      s_r.min_freq <= `MIN_FREQ_RST;
      s_r.match_frequency_band <= `BAND_RST;
      s_r.out_sel <= `OUT_SEL_RST;
      s_r.hold <= HOLD_IDLE;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.rdata;
  assign pready = s_r.ready;
  assign pslverr = 1'b0;
  assign contact_out = s_r.contacts;
  assign monitor_output = s_r.pulse_level;
  assign running_setpoint = s_r.setpoint;
endmodule // drive_terminal_function_logic

// ==== drive_terminal_function_logic_properties.sv ====
// port checker of the terminal function logic
`timescale 1ns/1ps
`include "drive_terminal_regs.svh"
module drive_terminal_checker (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic up_in,
  input wire logic down_in,
  input wire logic drive_running,
  input wire logic run_command,
  input wire logic fault_detected,
  input wire logic [3:0] contact_out,
  input wire logic monitor_output,
  input wire logic [15:0] running_setpoint
);
  logic ctrl_zero_r;
  logic sel_dflt_r;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // track whether control and selectors hold the values assumed below
  always_ff @(posedge clk_sys)
    if (reset)
    begin
      ctrl_zero_r <= 1'b0;
      sel_dflt_r <= 1'b1;
    end
    else if (psel && penable && pwrite && pready)
    begin
      if (paddr == `OFS_CTRL)
        ctrl_zero_r <= (pwdata == 32'h00000000);
      if (paddr == `OFS_OUT_SEL)
        sel_dflt_r <= (pwdata == `OUT_SEL_RST);
    end
  a_no_error: assert property (pslverr == 1'b0) else $error("slave error raised");
  a_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("ready not one wait state");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready longer than one cycle");
  a_idle_ready: assert property (!psel |=> !pready) else $error("ready without transfer");
  a_both_hold: assert property (up_in && down_in && drive_running && !psel
    |=> $stable(running_setpoint)) else $error("setpoint moved on both keys");
  a_up_step: assert property (ctrl_zero_r && drive_running && !psel && up_in && !down_in
    && $past(!up_in && !down_in) && running_setpoint != 16'h9C40
    |=> running_setpoint == $past(running_setpoint) + 16'h0001)
    else $error("up press not one step");
  a_down_step: assert property (ctrl_zero_r && drive_running && !psel && down_in && !up_in
    && $past(!up_in && !down_in) && running_setpoint > 16'h0032
    |=> running_setpoint == $past(running_setpoint) - 16'h0001)
    else $error("down press not one step");
  a_run_contact: assert property (sel_dflt_r
    |=> contact_out[0] == $past(drive_running || run_command))
    else $error("run contact wrong");
  a_fault_contact: assert property (sel_dflt_r |=> contact_out[2] == $past(fault_detected))
    else $error("fault contact wrong");
  a_idle_contact: assert property (sel_dflt_r |=> !contact_out[3])
    else $error("unused contact active");
  a_monitor_quiet: assert property (ctrl_zero_r |=> !monitor_output)
    else $error("pulse on analog monitor code");
endmodule // drive_terminal_checker
bind drive_terminal_function_logic drive_terminal_checker drive_terminal_checker_i (
  .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .up_in(up_in),
  .down_in(down_in), .drive_running(drive_running), .run_command(run_command),
  .fault_detected(fault_detected), .contact_out(contact_out),
  .monitor_output(monitor_output), .running_setpoint(running_setpoint));

// ==== terminal_field_model.sv ====
// counter pulse source and monitor pulse meter of the field side
`timescale 1ns/1ps
module terminal_field_model #(
  parameter int WIDTH = 6
)(
  input wire logic clk_sys,
  input wire logic go,
  input wire logic [3:0] n_pulses,
  input wire logic monitor_output,
  input wire logic meter_clr,
  output logic count_in,
  output logic busy,
  output int edges
);
  logic last;
  initial
  begin
    count_in = 1'b0;
    busy = 1'b0;
    forever
    begin
      @(posedge clk_sys);
      if (go)
      begin
        busy <= 1'b1;
        repeat (n_pulses)
        begin
          count_in <= 1'b1;
          repeat (WIDTH) @(posedge clk_sys);
          count_in <= 1'b0;
          repeat (WIDTH) @(posedge clk_sys);
        end
        busy <= 1'b0;
      end
    end
  end
  always @(posedge clk_sys)
  begin
    last <= monitor_output;
    if (meter_clr)
      edges <= 0;
    else if (monitor_output && !last)
      edges <= edges + 1;
  end
endmodule // terminal_field_model

// ==== drive_terminal_function_logic_tb_top.sv ====
// self-checking testbench of the terminal function logic
`timescale 1ns/1ps
`include "drive_terminal_regs.svh"
module drive_terminal_function_logic_tb_top;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic up_in = 1'b0;
  logic down_in = 1'b0;
  logic count_reset_in = 1'b0;
  logic drive_running = 1'b0;
  logic drawing_done = 1'b0;
  logic go = 1'b0;
  logic meter_clr = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] n_pulses = 4'h0;
  logic [5:0] ev = 6'h00;
  logic [15:0] output_frequency = 16'h0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, count_in, busy, monitor_output;
  logic [15:0] running_setpoint;
  logic [3:0] contact_out;
  logic [5:0] codes [6] = '{6'h01, 6'h02, 6'h08, 6'h09, 6'h0E, 6'h0F};
  int edges;
  int bad_count = 0;
  int num_checks = 0;
  drive_terminal_function_logic #(.DEBOUNCE_CYCLES(4), .FAST_CYCLES(8), .SLOW_CYCLES(16),
    .FAST_STEPS(3), .PULSE_DIV(10)) drive_terminal_function_logic_i (
    .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .up_in(up_in), .down_in(down_in), .count_in(count_in), .count_reset_in(count_reset_in),
    .output_frequency(output_frequency), .drive_running(drive_running),
    .run_command(ev[0]), .fault_detected(ev[1]), .accelerating(ev[2]),
    .decelerating(ev[3]), .step_done(ev[4]), .cycle_done(ev[5]),
    .drawing_done(drawing_done), .contact_out(contact_out),
    .monitor_output(monitor_output), .running_setpoint(running_setpoint));
  terminal_field_model terminal_field_model_i (.clk_sys(clk_sys), .go(go),
    .n_pulses(n_pulses), .monitor_output(monitor_output), .meter_clr(meter_clr),
    .count_in(count_in), .busy(busy), .edges(edges));
  initial
  begin
    forever
      #2.5 clk_sys = ~clk_sys;
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
    begin
      @(posedge clk_sys);
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic press(input logic u, input logic d, input int n, input logic [15:0] exp);
    up_in <= u;
    down_in <= d;
    repeat (n) @(posedge clk_sys);
    up_in <= 1'b0;
    down_in <= 1'b0;
    repeat (3) @(posedge clk_sys);
    bus(1'b0, `OFS_RUN_FREQ, 32'h00000000);
    chk(rd, {16'h0000, exp});
  endtask
  task automatic count(input logic [3:0] n, input logic [15:0] exp);
    n_pulses <= n;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    @(posedge clk_sys);
    while (busy === 1'b1)
    begin
      @(posedge clk_sys);
    end
    repeat (8) @(posedge clk_sys);
    bus(1'b0, `OFS_COUNT, 32'h00000000);
    chk(rd, {16'h0000, exp});
  endtask
  task automatic freq_chk(input logic [15:0] f, input logic exp);
    output_frequency <= f;
    repeat (3) @(posedge clk_sys);
    chk(contact_out[0], exp);
  endtask
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    bad_count++;
    test_done();
  end
  initial
  begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    bus(1'b0, `OFS_LIMITS, 32'h00000000);
    chk(rd, 32'h00009C40);
    bus(1'b0, `OFS_OUT_SEL, 32'h00000000);
    chk(rd, 32'h00020501);
    bus(1'b0, 12'h030, 32'h00000000);
    chk(rd, 32'h00000000);
    $display("reset values test ended");
    drive_running <= 1'b1;
    bus(1'b1, `OFS_CTRL, 32'h00000000);
    bus(1'b1, `OFS_CMD, 32'h00640001);
    bus(1'b0, `OFS_SETPOINT, 32'h00000000);
    chk(rd[15:0], 16'h0064);
    press(1'b1, 1'b0, 1, 16'h0065);
    press(1'b0, 1'b1, 1, 16'h0064);
    press(1'b1, 1'b1, 20, 16'h0064);
    press(1'b1, 1'b0, 36, 16'h0068);
    bus(1'b1, `OFS_CTRL, 32'h00000004);
    press(1'b1, 1'b0, 1, 16'h0072);
    bus(1'b1, `OFS_CTRL, 32'h00000001);
    press(1'b1, 1'b0, 5, 16'h0072);
    bus(1'b1, `OFS_CTRL, 32'h00000000);
    bus(1'b1, `OFS_CMD, 32'h9C3E0001);
    press(1'b1, 1'b0, 36, 16'h9C40);
    bus(1'b1, `OFS_LIMITS, 32'h00329C40);
    bus(1'b1, `OFS_CMD, 32'h00340001);
    press(1'b0, 1'b1, 36, 16'h0032);
    $display("up down test ended");
    bus(1'b1, `OFS_OUT_SEL, 32'h00001110);
    bus(1'b1, `OFS_COUNT_CFG, 32'h00020003);
    count(4'h2, 16'h0002);
    chk(contact_out[1:0], 2'b10);
    count(4'h1, 16'h0003);
    chk(contact_out[1:0], 2'b11);
    count(4'h2, 16'h0003);
    count_reset_in <= 1'b1;
    @(posedge clk_sys);
    count_reset_in <= 1'b0;
    count(4'h1, 16'h0001);
    $display("counter test ended");
    drive_running <= 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b1, `OFS_OUT_SEL, {26'h0, codes[i]});
      ev[i] <= 1'b1;
      @(posedge clk_sys);
      ev[i] <= 1'b0;
      #1 chk(contact_out[0], 1'b1);
      @(posedge clk_sys);
      #1 chk(contact_out[0], 1'b0);
      @(posedge clk_sys);
    end
    bus(1'b1, `OFS_OUT_SEL, 32'h0000001B);
    drive_running <= 1'b1;
    drawing_done <= 1'b1;
    @(posedge clk_sys);
    drawing_done <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(contact_out[0], 1'b1);
    drive_running <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(contact_out[0], 1'b0);
    bus(1'b1, `OFS_MATCH, 32'h00001000);
    bus(1'b1, `OFS_OUT_SEL, 32'h00000006);
    freq_chk(16'h1031, 1'b0);
    freq_chk(16'h1032, 1'b1);
    freq_chk(16'h0FCE, 1'b1);
    freq_chk(16'h0FCD, 1'b0);
    bus(1'b1, `OFS_OUT_SEL, 32'h00000005);
    freq_chk(16'h0034, 1'b1);
    freq_chk(16'h0033, 1'b0);
    bus(1'b1, `OFS_BAND, 32'h00100032);
    bus(1'b1, `OFS_OUT_SEL, 32'h00000003);
    freq_chk(16'h000F, 1'b1);
    freq_chk(16'h0010, 1'b0);
    $display("contact test ended");
    // 6 pulses per hz at 655.35 hz: first rise near 25440 cycles
    output_frequency <= 16'hFFFF;
    bus(1'b1, `OFS_CTRL, 32'h00000070);
    meter_clr <= 1'b0;
    repeat (20000) @(posedge clk_sys);
    chk(edges, 32'h00000000);
    repeat (10000) @(posedge clk_sys);
    chk(edges, 32'h00000001);
    bus(1'b1, `OFS_CTRL, 32'h00000000);
    meter_clr <= 1'b1;
    @(posedge clk_sys);
    meter_clr <= 1'b0;
    repeat (200) @(posedge clk_sys);
    chk(edges, 32'h00000000);
    $display("monitor test ended");
    test_done();
  end
endmodule // drive_terminal_function_logic_tb_top
